// *** pd_pkg.sv ***
/*
  Shared constants and types for the stacked-rank power-down link.
  Assumes both ends are compiled against this package and that the
  command pins are grouped in the order given by the field positions.
*/
package pd_pkg;

  localparam int RANK_BITS   = 2;
  localparam int NRANK       = 4;
  // Half period of the link clock in MCLK cycles (4 gives 400 ns at 10 MHz).
  localparam int CK_HALF     = 4;
  // Self-refresh exit wait, in link clock periods.
  localparam int XS_CYCLES   = 8;
  // Precharge wait before self-refresh, in link clock periods.
  localparam int RP_CYCLES   = 2;
  // Link periods an access keeps a rank busy after its command.
  localparam int BUSY_CYCLES = 6;

  // Command field {act_n, ras_n, cas_n, we_n}.
  localparam logic [3:0] CMD_NOP   = 4'hf;
  localparam logic [3:0] CMD_SRE   = 4'h9;
  localparam logic [3:0] CMD_REF   = 4'h9;
  localparam logic [3:0] CMD_PRE   = 4'ha;
  localparam logic [3:0] CMD_READ  = 4'hd;
  localparam logic [3:0] CMD_WRITE = 4'hc;
  localparam logic [3:0] CMD_MRS   = 4'h8;
  localparam logic [3:0] CMD_ZQ    = 4'he;
  localparam logic [3:0] CMD_ACT   = 4'h7;
  localparam int         CMD_ACT_BIT = 3;

  // Positions inside the sampled pin vector.
  localparam int PIN_CK  = 0;
  localparam int PIN_CKE = 1;
  localparam int PIN_CS  = 2;
  localparam int PIN_CMD = 3;
  localparam int PIN_C   = 7;
  localparam int PIN_ODT = PIN_C + RANK_BITS;
  localparam int PIN_W   = PIN_ODT + 1;

  typedef enum logic [1:0] {
    MODE_RUN = 2'h0,
    MODE_PD  = 2'h1,
    MODE_SR  = 2'h2,
    MODE_XS  = 2'h3
  } mode_type;

  typedef enum logic [2:0] {
    RS_IDLE     = 3'h0,
    RS_ACTIVE   = 3'h1,
    RS_PRE_PD   = 3'h2,
    RS_ACT_PD   = 3'h3,
    RS_SELF_REF = 3'h4
  } rank_state_type;

  typedef enum logic [3:0] {
    REQ_NOP   = 4'h0,
    REQ_ACT   = 4'h1,
    REQ_PRE   = 4'h2,
    REQ_READ  = 4'h3,
    REQ_WRITE = 4'h4,
    REQ_REF   = 4'h5,
    REQ_MRS   = 4'h6,
    REQ_ZQ    = 4'h7,
    REQ_PDE   = 4'h8,
    REQ_PDX   = 4'h9,
    REQ_SRE   = 4'ha,
    REQ_SRX   = 4'hb
  } req_type;

endpackage : pd_pkg

// *** pd_link_if.sv ***
/*
  Pin bundle between the memory controller end and the stacked device.
  Assumes the controller drives every pin and the device only listens.
*/
interface pd_link_if #(
  parameter int RANK_BITS = pd_pkg::RANK_BITS
);
  logic                 ck;
  logic                 cke;
  logic                 cs_n;
  logic                 act_n;
  logic                 ras_n;
  logic                 cas_n;
  logic                 we_n;
  logic [RANK_BITS-1:0] c;
  logic                 odt;

  modport ctrl (output ck, cke, cs_n, act_n, ras_n, cas_n, we_n, c, odt);
  modport dram (input  ck, cke, cs_n, act_n, ras_n, cas_n, we_n, c, odt);
endinterface : pd_link_if

// *** pd_controller.sv ***
/*
  Controller end: turns user requests into link commands and keeps
  the ranks legal before power-down and self-refresh entry.
  Assumes MCLK is free running; the link clock is divided from it.
*/
module pd_controller #(
  parameter int NRANK       = pd_pkg::NRANK,
  parameter int RANK_BITS   = pd_pkg::RANK_BITS,
  parameter int CK_HALF     = pd_pkg::CK_HALF,
  parameter int XS_CYCLES   = pd_pkg::XS_CYCLES,
  parameter int RP_CYCLES   = pd_pkg::RP_CYCLES,
  parameter int BUSY_CYCLES = pd_pkg::BUSY_CYCLES
) (
  input  wire logic             MCLK,
  input  wire logic             RESET,
  input  wire logic             REQ,
  input  pd_pkg::req_type       REQ_CMD,
  input  wire logic [RANK_BITS-1:0] REQ_RANK,
  input  wire logic             REQ_CS_OFF,
  input  wire logic             ODT_REQ,
  output logic                  READY,
  output logic                  REJECT,
  output pd_pkg::mode_type      MODE,
  pd_link_if.ctrl               LINK
);
  localparam int DW = $clog2(2 * CK_HALF);
  localparam int CW = $clog2(XS_CYCLES + RP_CYCLES + BUSY_CYCLES + 1);

  logic [DW-1:0]        div_ff;
  logic                 ck_ff;
  logic                 pend_ff;
  pd_pkg::req_type      pcmd_ff;
  logic [RANK_BITS-1:0] prank_ff;
  logic                 pcs_off_ff;
  pd_pkg::mode_type     mode_ff, nxt_mode;
  logic [NRANK-1:0]     open_ff, nxt_open;
  logic [CW-1:0]        busy_ff, rp_ff, xs_ff;
  logic                 cke_ff, cs_n_ff, odt_ff, reject_ff;
  logic [3:0]           cmd_ff;
  logic [RANK_BITS-1:0] c_ff;

  function automatic logic [3:0] code_of(input pd_pkg::req_type r);
    case (r)
      pd_pkg::REQ_ACT:   code_of = pd_pkg::CMD_ACT;
      pd_pkg::REQ_PRE:   code_of = pd_pkg::CMD_PRE;
      pd_pkg::REQ_READ:  code_of = pd_pkg::CMD_READ;
      pd_pkg::REQ_WRITE: code_of = pd_pkg::CMD_WRITE;
      pd_pkg::REQ_REF:   code_of = pd_pkg::CMD_REF;
      pd_pkg::REQ_MRS:   code_of = pd_pkg::CMD_MRS;
      pd_pkg::REQ_ZQ:    code_of = pd_pkg::CMD_ZQ;
      pd_pkg::REQ_SRE:   code_of = pd_pkg::CMD_SRE;
      default:           code_of = pd_pkg::CMD_NOP;
    endcase
  endfunction : code_of

  // Pins change on the MCLK edge where the link clock falls, half a period ahead
  // of the rising edge on which the device samples them.
  wire slot      = (div_ff == DW'(CK_HALF - 1));
  wire quiet     = (busy_ff == '0);
  wire sr_ok     = quiet & (open_ff == '0) & (rp_ff == '0);
  wire is_pde    = pcmd_ff == pd_pkg::REQ_PDE;
  wire is_sre    = pcmd_ff == pd_pkg::REQ_SRE;
  wire is_pdx    = pcmd_ff == pd_pkg::REQ_PDX;
  wire is_srx    = pcmd_ff == pd_pkg::REQ_SRX;
  wire is_access = pcmd_ff inside {pd_pkg::REQ_READ, pd_pkg::REQ_WRITE,
                                   pd_pkg::REQ_MRS, pd_pkg::REQ_ZQ};
  wire run_ok    = is_pde ? quiet : is_sre ? sr_ok : ~(is_pdx | is_srx);
  wire legal     = (mode_ff == pd_pkg::MODE_RUN) ? run_ok :
                   (mode_ff == pd_pkg::MODE_PD)  ? is_pdx :
                   (mode_ff == pd_pkg::MODE_SR)  ? is_srx : 1'b0;
  // Requests wait out the exit delay instead of being refused.
  wire hold      = mode_ff == pd_pkg::MODE_XS;
  wire issue     = slot & pend_ff & ~hold & legal;
  wire refuse    = slot & pend_ff & ~hold & ~legal;

  assign READY  = ~pend_ff;
  assign REJECT = reject_ff;
  assign MODE   = mode_ff;
  assign LINK.ck    = ck_ff;
  assign LINK.cke   = cke_ff;
  assign LINK.cs_n  = cs_n_ff;
  assign LINK.act_n = cmd_ff[pd_pkg::CMD_ACT_BIT];
  assign LINK.ras_n = cmd_ff[2];
  assign LINK.cas_n = cmd_ff[1];
  assign LINK.we_n  = cmd_ff[0];
  assign LINK.c     = c_ff;
  assign LINK.odt   = odt_ff;

  always_comb begin
    nxt_mode = mode_ff;
    nxt_open = open_ff;
    if (issue) begin
      case (pcmd_ff)
        pd_pkg::REQ_ACT: nxt_open[prank_ff] = 1'b1;
        pd_pkg::REQ_PRE: nxt_open[prank_ff] = 1'b0;
        pd_pkg::REQ_PDE: nxt_mode = pd_pkg::MODE_PD;
        // An unselected entry lands in power-down, as the device does.
        pd_pkg::REQ_SRE: nxt_mode = pcs_off_ff ? pd_pkg::MODE_PD
                                               : pd_pkg::MODE_SR;
        pd_pkg::REQ_PDX: nxt_mode = pd_pkg::MODE_RUN;
        pd_pkg::REQ_SRX: nxt_mode = pd_pkg::MODE_XS;
        default: nxt_mode = mode_ff;
      endcase
    end else if (slot && hold && xs_ff == CW'(1)) begin
      nxt_mode = pd_pkg::MODE_RUN;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      div_ff <= '0;
      ck_ff  <= 1'b1;
    end else begin
      div_ff <= (div_ff == DW'(2 * CK_HALF - 1)) ? '0 : div_ff + 1'b1;
      ck_ff  <= (div_ff == DW'(2 * CK_HALF - 1)) | (div_ff < DW'(CK_HALF - 1));
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      pend_ff    <= 1'b0;
      pcmd_ff    <= pd_pkg::REQ_NOP;
      prank_ff   <= '0;
      pcs_off_ff <= 1'b0;
    end else if (REQ && !pend_ff) begin
      pend_ff    <= 1'b1;
      pcmd_ff    <= REQ_CMD;
      prank_ff   <= REQ_RANK;
      pcs_off_ff <= REQ_CS_OFF;
    end else if (issue || refuse) begin
      pend_ff    <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      mode_ff   <= pd_pkg::MODE_RUN;
      open_ff   <= '0;
      busy_ff   <= '0;
      rp_ff     <= '0;
      xs_ff     <= '0;
      cke_ff    <= 1'b1;
      cs_n_ff   <= 1'b1;
      cmd_ff    <= pd_pkg::CMD_NOP;
      c_ff      <= '0;
      odt_ff    <= 1'b0;
      reject_ff <= 1'b0;
    end else begin
      mode_ff   <= nxt_mode;
      open_ff   <= nxt_open;
      reject_ff <= refuse;
      if (slot) begin
        busy_ff <= (issue && is_access) ? CW'(BUSY_CYCLES)
                 : (busy_ff != '0) ? busy_ff - 1'b1 : busy_ff;
        rp_ff   <= (issue && pcmd_ff == pd_pkg::REQ_PRE) ? CW'(RP_CYCLES)
                 : (rp_ff != '0) ? rp_ff - 1'b1 : rp_ff;
        xs_ff   <= (issue && is_srx) ? CW'(XS_CYCLES)
                 : (xs_ff != '0) ? xs_ff - 1'b1 : xs_ff;
        cke_ff  <= (nxt_mode == pd_pkg::MODE_RUN) |
                   (nxt_mode == pd_pkg::MODE_XS);
        cs_n_ff <= ~issue | is_pde | is_pdx | is_srx |
                   (is_sre & pcs_off_ff);
        cmd_ff  <= issue ? code_of(pcmd_ff) : pd_pkg::CMD_NOP;
        c_ff    <= issue ? prank_ff : c_ff;
        odt_ff  <= ODT_REQ;
      end
    end
  end

endmodule : pd_controller

// *** rank_pd_device.sv ***
/*
  Device end: shared clock-enable power-down and self-refresh handling
  for a stack of logical ranks behind one command interface.
  Assumes the link pins come from another clock domain and change only
  while the link clock is low; MR_TERM_EN is on the MCLK domain.
*/
// What this block does
// - Unselected self-refresh code enters power-down instead.
// - Controller holds rank select at defined levels.
// - After exit delay any rank accepts commands.
// - Controller settles all ranks before lowering clock-enable.
// - Power-down entry needs clock-enable low with idle command.
// - No clock-enable low during busy operations.
// - Each rank picks precharge or active power-down.
// - Shared termination input applies to every rank.
// - Controller refuses self-refresh until all ranks are precharged.
// - Self-refresh code moves all ranks together.
module rank_pd_device #(
  parameter int NRANK     = pd_pkg::NRANK,
  parameter int RANK_BITS = pd_pkg::RANK_BITS,
  parameter int XS_CYCLES = pd_pkg::XS_CYCLES
) (
  input  wire logic                   MCLK,
  input  wire logic                   RESET,
  pd_link_if.dram                     LINK,
  input  wire logic                   MR_TERM_EN,
  output logic [NRANK-1:0][2:0]       RANK_STATE,
  output logic [NRANK-1:0]            TERM_ON,
  output logic                        CMD_VALID,
  output logic [3:0]                  CMD_CODE,
  output logic [RANK_BITS-1:0]        CMD_RANK,
  output logic                        XS_WAIT,
  output pd_pkg::mode_type            MODE
);
  localparam int XW = $clog2(XS_CYCLES + 1);

  logic [pd_pkg::PIN_W-1:0] meta_ff;
  logic [pd_pkg::PIN_W-1:0] sync_ff;
  logic                     ck_last_ff;
  logic                     cke_prev_ff;
  pd_pkg::mode_type         mode_ff;
  pd_pkg::mode_type         nxt_mode;
  logic [NRANK-1:0]         open_ff;
  logic [NRANK-1:0]         nxt_open;
  logic [XW-1:0]            xs_ff;
  logic [XW-1:0]            nxt_xs;
  logic [NRANK-1:0][2:0]    state_ff;
  logic [NRANK-1:0][2:0]    nxt_state;
  logic [NRANK-1:0]         term_ff;
  logic                     valid_ff;
  logic [3:0]               code_ff;
  logic [RANK_BITS-1:0]     rank_ff;

  // A rank's state follows from the global mode and whether it has
  // an open row.
  function automatic pd_pkg::rank_state_type state_of(
    input pd_pkg::mode_type m,
    input logic             open
  );
    case (m)
      pd_pkg::MODE_PD: state_of = open ? pd_pkg::RS_ACT_PD
                                       : pd_pkg::RS_PRE_PD;
      pd_pkg::MODE_SR: state_of = pd_pkg::RS_SELF_REF;
      default:         state_of = open ? pd_pkg::RS_ACTIVE
                                       : pd_pkg::RS_IDLE;
    endcase
  endfunction : state_of

  // Every pin, the link clock included, goes through the same two
  // stages so that their relative timing is kept.
  wire [pd_pkg::PIN_W-1:0] pins_raw = {
    LINK.odt, LINK.c, LINK.act_n, LINK.ras_n, LINK.cas_n, LINK.we_n,
    LINK.cs_n, LINK.cke, LINK.ck
  };

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      meta_ff    <= '1;
      sync_ff    <= '1;
      ck_last_ff <= 1'b1;
    end else begin
      meta_ff    <= pins_raw;
      sync_ff    <= meta_ff;
      ck_last_ff <= sync_ff[pd_pkg::PIN_CK];
    end
  end

  wire                 ck_rise = sync_ff[pd_pkg::PIN_CK] & ~ck_last_ff;
  wire                 cke     = sync_ff[pd_pkg::PIN_CKE];
  wire                 cs_n    = sync_ff[pd_pkg::PIN_CS];
  wire [3:0]           cmd     = sync_ff[pd_pkg::PIN_CMD +: 4];
  wire [RANK_BITS-1:0] rank    = sync_ff[pd_pkg::PIN_C +: RANK_BITS];
  wire                 odt     = sync_ff[pd_pkg::PIN_ODT];

  wire in_run   = mode_ff == pd_pkg::MODE_RUN;
  wire in_xs    = mode_ff == pd_pkg::MODE_XS;
  // Entry is judged on the edge where clock-enable is first seen low.
  wire low_edge = ck_rise & cke_prev_ff & ~cke;
  wire sre_code = cmd == pd_pkg::CMD_SRE;
  // A deselect is idle whatever the command pins show, which is what
  // turns an unselected self-refresh code into a power-down entry.
  wire idle_cmd = cs_n | (cmd == pd_pkg::CMD_NOP);
  // Rank select is not looked at: all ranks move together.
  wire go_sr    = in_run & low_edge & sre_code & ~cs_n;
  wire go_pd    = in_run & low_edge & idle_cmd;
  wire wake     = ck_rise & cke;
  wire live_cmd = in_run & ck_rise & cke & cke_prev_ff & ~idle_cmd;
  wire is_act   = ~cmd[pd_pkg::CMD_ACT_BIT];
  wire is_pre   = cmd == pd_pkg::CMD_PRE;

  // Clock-enable low with any other command is not an entry; the
  // device stays up and the command is dropped.
  always_comb begin
    nxt_mode = mode_ff;
    nxt_xs   = xs_ff;
    case (mode_ff)
      pd_pkg::MODE_RUN: begin
        if (go_sr) begin
          nxt_mode = pd_pkg::MODE_SR;
        end else if (go_pd) begin
          nxt_mode = pd_pkg::MODE_PD;
        end
      end
      pd_pkg::MODE_PD: begin
        if (wake) begin
          nxt_mode = pd_pkg::MODE_RUN;
        end
      end
      pd_pkg::MODE_SR: begin
        if (wake) begin
          nxt_mode = pd_pkg::MODE_XS;
          nxt_xs   = XW'(XS_CYCLES);
        end
      end
      pd_pkg::MODE_XS: begin
        if (ck_rise) begin
          nxt_xs = xs_ff - 1'b1;
          if (xs_ff == XW'(1)) begin
            nxt_mode = pd_pkg::MODE_RUN;
          end
        end
      end
      default: nxt_mode = pd_pkg::MODE_RUN;
    endcase
  end

  // Open rows are tracked per rank so that power-down lands each rank
  // in the state its rows call for.
  always_comb begin
    nxt_open = open_ff;
    if (live_cmd && is_act) begin
      nxt_open[rank] = 1'b1;
    end else if (live_cmd && is_pre) begin
      nxt_open[rank] = 1'b0;
    end
    for (int r = 0; r < NRANK; r++) begin
      nxt_state[r] = state_of(nxt_mode, nxt_open[r]);
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      cke_prev_ff <= 1'b1;
      mode_ff     <= pd_pkg::MODE_RUN;
      xs_ff       <= '0;
      open_ff     <= '0;
      state_ff    <= '0;
    end else begin
      if (ck_rise) begin
        cke_prev_ff <= cke;
      end
      mode_ff  <= nxt_mode;
      xs_ff    <= nxt_xs;
      open_ff  <= nxt_open;
      state_ff <= nxt_state;
    end
  end

  // Termination is not steered by the rank select pins; the one input
  // applies to every rank once enabled.
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      term_ff <= '0;
    end else begin
      term_ff <= {NRANK{MR_TERM_EN & odt}};
    end
  end

  // Decoded commands are reported on the user side; commands during
  // the exit wait are not reported because they are not accepted.
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      valid_ff <= 1'b0;
      code_ff  <= pd_pkg::CMD_NOP;
      rank_ff  <= '0;
    end else begin
      valid_ff <= live_cmd;
      if (live_cmd) begin
        code_ff <= cmd;
        rank_ff <= rank;
      end
    end
  end

  assign RANK_STATE = state_ff;
  assign TERM_ON    = term_ff;
  assign CMD_VALID  = valid_ff;
  assign CMD_CODE   = code_ff;
  assign CMD_RANK   = rank_ff;
  assign XS_WAIT    = in_xs;
  assign MODE       = mode_ff;

endmodule : rank_pd_device

// *** pd_link_props.sv ***
/*
  Checker for the link pins between controller end and device end.
  Assumes it is instantiated beside the interface and sees the pins
  on MCLK, with RESET asynchronous and active high.
*/
module pd_link_props #(
  parameter int NRANK       = pd_pkg::NRANK,
  parameter int RANK_BITS   = pd_pkg::RANK_BITS,
  parameter int XS_CYCLES   = pd_pkg::XS_CYCLES,
  parameter int RP_CYCLES   = pd_pkg::RP_CYCLES,
  parameter int BUSY_CYCLES = pd_pkg::BUSY_CYCLES
) (
  input wire logic                 MCLK,
  input wire logic                 RESET,
  input wire logic                 ck,
  input wire logic                 cke,
  input wire logic                 cs_n,
  input wire logic                 act_n,
  input wire logic                 ras_n,
  input wire logic                 cas_n,
  input wire logic                 we_n,
  input wire logic [RANK_BITS-1:0] c,
  input wire logic                 odt
);
  timeunit 1ns;
  timeprecision 100ps;

  logic             ck_q_ff;
  logic             cke_q_ff;
  logic             in_sr_ff;
  logic [7:0]       busy_ff;
  logic [7:0]       rp_ff;
  logic [7:0]       xs_ff;
  logic [NRANK-1:0] open_ff;

  wire [3:0]       cmd  = {act_n, ras_n, cas_n, we_n};
  wire             rise = ck & ~ck_q_ff;
  wire             sel  = rise & ~cs_n;
  wire [NRANK-1:0] hot  = NRANK'(1) << c;
  wire busy_cmd = sel & (cmd == pd_pkg::CMD_READ | cmd == pd_pkg::CMD_WRITE
                  | cmd == pd_pkg::CMD_MRS | cmd == pd_pkg::CMD_ZQ);
  wire pre_cmd  = sel & (cmd == pd_pkg::CMD_PRE);
  wire act_cmd  = sel & (cmd == pd_pkg::CMD_ACT);
  wire sre_go   = cke_q_ff & ~cke & ~cs_n & (cmd == pd_pkg::CMD_SRE);
  wire sr_exit  = ~cke_q_ff & cke & in_sr_ff;
  // Loads equal the controller's counts; the exit wait adds the wake rise.
  wire [7:0] nxt_busy = busy_cmd ? 8'(BUSY_CYCLES) :
                        (rise && busy_ff != 8'h00) ? busy_ff - 8'h01 : busy_ff;
  wire [7:0] nxt_rp   = pre_cmd ? 8'(RP_CYCLES) :
                        (rise && rp_ff != 8'h00) ? rp_ff - 8'h01 : rp_ff;
  wire [7:0] nxt_xs   = sr_exit ? 8'(XS_CYCLES + 1) :
                        (rise && xs_ff != 8'h00) ? xs_ff - 8'h01 : xs_ff;
  wire [NRANK-1:0] nxt_open = act_cmd ? (open_ff | hot) :
                              pre_cmd ? (open_ff & ~hot) : open_ff;
  wire nxt_in_sr = sre_go | (in_sr_ff & ~cke);

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      {ck_q_ff, cke_q_ff, in_sr_ff} <= 3'h6;
      {busy_ff, rp_ff, xs_ff} <= 24'h000000;
      open_ff <= '0;
    end else begin
      {ck_q_ff, cke_q_ff, in_sr_ff} <= {ck, cke, nxt_in_sr};
      {busy_ff, rp_ff, xs_ff} <= {nxt_busy, nxt_rp, nxt_xs};
      open_ff <= nxt_open;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence s_link_period;
    ck [*4] ##1 !ck [*4] ##1 ck;
  endsequence
  sequence s_held_low;
    $fell(cke) ##1 !cke [*8];
  endsequence

  property p_ck_shape;
    $rose(ck) |-> s_link_period;
  endproperty
  property p_pins_hold;
    ck && $past(ck) |-> $stable({cke, cs_n, cmd, c, odt});
  endproperty
  property p_entry_idle;
    $fell(cke) |-> cs_n || cmd == pd_pkg::CMD_NOP || cmd == pd_pkg::CMD_SRE;
  endproperty
  property p_entry_not_busy;
    $fell(cke) |-> busy_ff == 8'h00;
  endproperty
  property p_sre_precharged;
    $fell(cke) && !cs_n && cmd == pd_pkg::CMD_SRE |->
      open_ff == '0 && rp_ff == 8'h00;
  endproperty
  property p_pd_quiet;
    s_held_low |-> cs_n;
  endproperty
  property p_exit_deselect;
    $rose(cke) |-> cs_n;
  endproperty
  property p_xs_quiet;
    $rose(ck) && xs_ff != 8'h00 |-> cs_n;
  endproperty

  a_ck_shape: assert property (p_ck_shape)
    else $error("link clock period is not eight cycles");
  a_pins_hold: assert property (p_pins_hold)
    else $error("link pins moved while link clock high");
  a_entry_idle: assert property (p_entry_idle)
    else $error("clock enable fell with a real command");
  a_entry_not_busy: assert property (p_entry_not_busy)
    else $error("clock enable fell during a busy access");
  a_sre_precharged: assert property (p_sre_precharged)
    else $error("self refresh entered with a rank not precharged");
  a_pd_quiet: assert property (p_pd_quiet)
    else $error("command sent while clock enable held low");
  a_exit_deselect: assert property (p_exit_deselect)
    else $error("clock enable rose without deselect");
  a_xs_quiet: assert property (p_xs_quiet)
    else $error("command sent inside self refresh exit wait");

  c_sre: cover property ($fell(cke) && !cs_n && cmd == pd_pkg::CMD_SRE);
endmodule : pd_link_props

// *** stacked_rank_power_down_control_tb_top.sv ***
/*
  Bench joining the controller end and the device end over the link.
  Assumes the package defaults; drives user inputs 1 ns after MCLK.
*/
module stacked_rank_power_down_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic                        mclk;
  logic                        reset;
  logic                        req;
  pd_pkg::req_type             req_cmd;
  logic [1:0]                  req_rank;
  logic                        req_cs_off;
  logic                        odt_req;
  logic                        ready;
  logic                        reject;
  pd_pkg::mode_type            ctl_mode;
  logic                        mr_term_en;
  logic [pd_pkg::NRANK-1:0][2:0] rank_state;
  logic [3:0]                  term_on;
  logic                        cmd_valid;
  logic [3:0]                  cmd_code;
  logic [1:0]                  cmd_rank;
  logic                        xs_wait;
  pd_pkg::mode_type            dev_mode;
  logic                        rejected;
  int                          n_fail;
  int                          comparisons;
  int                          n_cmd = 0;
  int                          cyc = 0;

  pd_link_if link_if ();

  pd_controller pd_controller_inst (.MCLK(mclk), .RESET(reset), .REQ(req),
    .REQ_CMD(req_cmd), .REQ_RANK(req_rank), .REQ_CS_OFF(req_cs_off),
    .ODT_REQ(odt_req), .READY(ready), .REJECT(reject), .MODE(ctl_mode),
    .LINK(link_if));
  rank_pd_device rank_pd_device_inst (.MCLK(mclk), .RESET(reset),
    .LINK(link_if), .MR_TERM_EN(mr_term_en), .RANK_STATE(rank_state),
    .TERM_ON(term_on), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
    .CMD_RANK(cmd_rank), .XS_WAIT(xs_wait), .MODE(dev_mode));
  pd_link_props pd_link_props_inst (.MCLK(mclk), .RESET(reset),
    .ck(link_if.ck), .cke(link_if.cke), .cs_n(link_if.cs_n),
    .act_n(link_if.act_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n),
    .we_n(link_if.we_n), .c(link_if.c), .odt(link_if.odt));

  always #50 mclk = ~mclk;

  always @(posedge mclk) begin
    if (cmd_valid === 1'b1) n_cmd++;
  end

  // The ceiling is more than twenty times the expected length of the run.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task check(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [11:0] mix(input int k,
      input pd_pkg::rank_state_type hit, input pd_pkg::rank_state_type rest);
    logic [11:0] v;
    for (int i = 0; i < 4; i++) v[i*3 +: 3] = (i == k) ? hit : rest;
    return v;
  endfunction : mix

  task settle;
    repeat (24) @(posedge mclk);
    #1;
  endtask : settle

  // Holds the request until the edge that takes it, then waits for the
  // issue or the refusal pulse.
  task do_req(input pd_pkg::req_type cmd, input logic [1:0] rk,
              input logic off);
    int n;
    n = 0;
    rejected = 1'b0;
    {req, req_cmd, req_rank, req_cs_off} = {1'b1, cmd, rk, off};
    while (ready !== 1'b1 && n < 400) begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    #1;
    req = 1'b0;
    do begin
      @(posedge mclk);
      #1;
      if (reject === 1'b1) rejected = 1'b1;
      n++;
    end while (ready !== 1'b1 && n < 800);
    repeat (2) begin
      @(posedge mclk);
      #1;
      if (reject === 1'b1) rejected = 1'b1;
    end
  endtask : do_req

  task t_reset_values;
    check("ready", ready, 1'b1);
    check("reject", reject, 1'b0);
    check("ctl mode", ctl_mode, pd_pkg::MODE_RUN);
    check("dev mode", dev_mode, pd_pkg::MODE_RUN);
    check("ranks", rank_state, mix(0, pd_pkg::RS_IDLE, pd_pkg::RS_IDLE));
    check("term", term_on, 4'h0);
    check("xs wait", xs_wait, 1'b0);
  endtask : t_reset_values

  task t_power_down;
    do_req(pd_pkg::REQ_ACT, 2'h1, 1'b0);
    do_req(pd_pkg::REQ_PDE, 2'h0, 1'b0);
    check("pde taken", rejected, 1'b0);
    settle();
    check("pd mode", dev_mode, pd_pkg::MODE_PD);
    check("pd ranks", rank_state,
          mix(1, pd_pkg::RS_ACT_PD, pd_pkg::RS_PRE_PD));
    check("cke low", link_if.cke, 1'b0);
    do_req(pd_pkg::REQ_READ, 2'h1, 1'b0);
    check("read in pd", rejected, 1'b1);
    do_req(pd_pkg::REQ_PDX, 2'h0, 1'b0);
    settle();
    check("pd exit", dev_mode, pd_pkg::MODE_RUN);
    check("ranks back", rank_state,
          mix(1, pd_pkg::RS_ACTIVE, pd_pkg::RS_IDLE));
    do_req(pd_pkg::REQ_PRE, 2'h1, 1'b0);
    settle();
  endtask : t_power_down

  task t_unselected_sre;
    do_req(pd_pkg::REQ_SRE, 2'h2, 1'b1);
    settle();
    check("unsel mode", dev_mode, pd_pkg::MODE_PD);
    check("unsel ranks", rank_state,
          mix(0, pd_pkg::RS_PRE_PD, pd_pkg::RS_PRE_PD));
    do_req(pd_pkg::REQ_PDX, 2'h0, 1'b0);
    settle();
    check("unsel exit", dev_mode, pd_pkg::MODE_RUN);
  endtask : t_unselected_sre

  task t_busy_refuse;
    do_req(pd_pkg::REQ_READ, 2'h0, 1'b0);
    do_req(pd_pkg::REQ_PDE, 2'h0, 1'b0);
    check("pde busy", rejected, 1'b1);
    check("still run", ctl_mode, pd_pkg::MODE_RUN);
    do_req(pd_pkg::REQ_PDX, 2'h0, 1'b0);
    check("pdx in run", rejected, 1'b1);
    repeat (60) @(posedge mclk);
    #1;
    do_req(pd_pkg::REQ_PDE, 2'h0, 1'b0);
    check("pde later", rejected, 1'b0);
    do_req(pd_pkg::REQ_PDX, 2'h0, 1'b0);
    settle();
  endtask : t_busy_refuse

  task t_sre_guard;
    do_req(pd_pkg::REQ_ACT, 2'h2, 1'b0);
    do_req(pd_pkg::REQ_SRE, 2'h0, 1'b0);
    check("sre open", rejected, 1'b1);
    do_req(pd_pkg::REQ_PRE, 2'h2, 1'b0);
    do_req(pd_pkg::REQ_SRE, 2'h0, 1'b0);
    check("sre in rp", rejected, 1'b1);
    settle();
  endtask : t_sre_guard

  task t_self_refresh;
    int n0;
    int n;
    do_req(pd_pkg::REQ_SRE, 2'h1, 1'b0);
    check("sre taken", rejected, 1'b0);
    settle();
    check("sr mode", dev_mode, pd_pkg::MODE_SR);
    check("sr ranks", rank_state,
          mix(0, pd_pkg::RS_SELF_REF, pd_pkg::RS_SELF_REF));
    n0 = n_cmd;
    do_req(pd_pkg::REQ_SRX, 2'h0, 1'b0);
    n = 0;
    while (xs_wait !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("xs wait", xs_wait, 1'b1);
    {mr_term_en, odt_req} = 2'h3;
    do_req(pd_pkg::REQ_ACT, 2'h3, 1'b0);
    settle();
    check("xs over", xs_wait, 1'b0);
    check("cmd count", n_cmd, n0 + 1);
    check("cmd code", cmd_code, pd_pkg::CMD_ACT);
    check("cmd rank", cmd_rank, 2'h3);
    check("rank3", rank_state,
          mix(3, pd_pkg::RS_ACTIVE, pd_pkg::RS_IDLE));
    check("term all", term_on, 4'hf);
    odt_req = 1'b0;
    settle();
    check("term odt off", term_on, 4'h0);
    {mr_term_en, odt_req} = 2'h1;
    settle();
    check("term mr off", term_on, 4'h0);
    odt_req = 1'b0;
    do_req(pd_pkg::REQ_PRE, 2'h3, 1'b0);
    do_req(pd_pkg::REQ_ZQ, 2'h0, 1'b0);
    do_req(pd_pkg::REQ_PDE, 2'h0, 1'b0);
    check("pde zq", rejected, 1'b1);
    settle();
  endtask : t_self_refresh

  initial begin
    {mclk, reset, req, req_rank, req_cs_off, odt_req, mr_term_en} = 8'h40;
    req_cmd = pd_pkg::REQ_NOP;
    n_fail = 0;
    comparisons = 0;
    repeat (20) @(posedge mclk);
    #1;
    reset = 1'b0;
    t_reset_values();
    t_power_down();
    t_unselected_sre();
    t_busy_refuse();
    t_sre_guard();
    t_self_refresh();
    final_report();
  end
endmodule : stacked_rank_power_down_control_tb_top
